/* tmr_pkg.sv */
// constants, field layout and mode encoding of the multimode timer channel
// assumes a single 125 MHz clock domain and a plain address/strobe register port
// Contract
// - after reset the start flag is 0; counting waits for software to set it
// - reading the count while running returns the live counter, count keeps going
// - timer mode: a read coinciding with reload returns all ones
// - event mode: read at reload gives all ones on underflow, zeros on overflow
// - count written while halted reads back before counting begins
// - channels 2, 3 and 4 count two-phase pulses from phase and output pins
// - one-shot: clearing start mid-count stops, reloads, drives output low, requests interrupt
// - one-shot output follows the internal count source, up to one source cycle late
// - selecting one-shot after reset or from timer/event mode requests an interrupt
// - one-shot retrigger: one more decrement, then reload and keep counting
// - selecting PWM after reset or from timer/event mode requests an interrupt
// - PWM: clearing start stops; a high output goes low and requests an interrupt
// - PWM: clearing start with output low leaves pin and request unchanged
package tmr_pkg;
  localparam int CNT_W = 16;
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_COUNT = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_STAT = 4'h8;
  localparam logic [ADDR_W-1:0] ADDR_MASK = 4'hc;
  localparam int CTRL_START = 0;
  localparam int CTRL_MODE = 1;
  localparam int CTRL_TRIG_EXT = 3;
  localparam int CTRL_UP = 4;
  localparam int CTRL_FREE = 5;
  localparam int CTRL_TWO_PH = 6;
  localparam int CTRL_SW_TRIG = 7;
  localparam int STAT_IRQ = 0;
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONES = 16'hffff;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam int SRC_DIV_DEF = 4;
  localparam int CH_IDX_DEF = 2;
  localparam int PIN_N = 3;
  localparam int PIN_TRIG = 0;
  localparam int PIN_PHASE = 1;
  localparam int PIN_OUT = 2;
  typedef enum logic [1:0] {
    MODE_TIMER = 2'b00,
    MODE_EVENT = 2'b01,
    MODE_ONESHOT = 2'b10,
    MODE_PWM = 2'b11
  } mode_t;
endpackage : tmr_pkg

/* pin_if.sv */
// filtered pin levels and edges passed from the synchroniser to the channel
// assumes both ends run on ref_clk
`timescale 1ns/1ps
interface pin_if #(parameter int N = 3);
  logic [N-1:0] lvl;
  logic [N-1:0] rise;
  logic [N-1:0] fall;
  modport src (output lvl, output rise, output fall);
  modport dst (input lvl, input rise, input fall);
endinterface : pin_if

/* pin_sync.sv */
// three-flop synchroniser with agreement filter for asynchronous pins
// assumes pins are asynchronous to ref_clk
`timescale 1ns/1ps
module pin_sync #(
  parameter int N = 3
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [N-1:0] pin,
  pin_if.src sync
);
  logic [N-1:0] s1_r, s2_r, s3_r, lvl_r, rise_r, fall_r;
  logic [N-1:0] lvl_nxt, rise_nxt, fall_nxt;

  always_comb begin
    lvl_nxt = lvl_r;
    for (int i = 0; i < N; i++) begin
      // a change counts once the second and third stages agree
      if (s2_r[i] == s3_r[i]) begin
        lvl_nxt[i] = s2_r[i];
      end
    end
    rise_nxt = lvl_nxt & ~lvl_r;
    fall_nxt = ~lvl_nxt & lvl_r;
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      lvl_r <= '0;
      rise_r <= '0;
      fall_r <= '0;
    end else begin
      s1_r <= pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
      lvl_r <= lvl_nxt;
      rise_r <= rise_nxt;
      fall_r <= fall_nxt;
    end
  end

  assign sync.lvl = lvl_r;
  assign sync.rise = rise_r;
  assign sync.fall = fall_r;
endmodule : pin_sync

/* timer_a_multimode_counter.sv */
// one timer channel: timer, event counter, one-shot and PWM modes with register port
// assumes software drives single-cycle strobes on ref_clk; pins are asynchronous
`timescale 1ns/1ps
module timer_a_multimode_counter #(
  parameter int SRC_DIV = tmr_pkg::SRC_DIV_DEF,
  parameter int CH_IDX = tmr_pkg::CH_IDX_DEF
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [tmr_pkg::ADDR_W-1:0] addr,
  input wire logic [tmr_pkg::CNT_W-1:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [tmr_pkg::CNT_W-1:0] rdata,
  input wire logic timer_trigger_input_pin,
  input wire logic timer_phase_input_pin,
  input wire logic timer_output_pin_in,
  output logic timer_output_pin_out,
  output logic timer_output_pin_oe,
  output logic irq
);
  localparam bit TWO_PH_OK = (CH_IDX >= 2) && (CH_IDX <= 4);
  localparam int DIV_W = (SRC_DIV > 1) ? $clog2(SRC_DIV) : 1;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SRC_DIV - 1);

  function automatic logic [tmr_pkg::CNT_W-1:0] step(input logic [tmr_pkg::CNT_W-1:0] v, input logic up);
    step = up ? tmr_pkg::CNT_W'(v + 1'b1) : tmr_pkg::CNT_W'(v - 1'b1);
  endfunction : step

  function automatic logic timed_mode(input tmr_pkg::mode_t m);
    timed_mode = (m == tmr_pkg::MODE_TIMER) || (m == tmr_pkg::MODE_EVENT);
  endfunction : timed_mode

  pin_if #(.N(tmr_pkg::PIN_N)) pins ();

  pin_sync #(.N(tmr_pkg::PIN_N)) u_sync (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .pin({timer_output_pin_in, timer_phase_input_pin, timer_trigger_input_pin}),
    .sync(pins)
  );

  // count source divider
  logic [DIV_W-1:0] div_r, div_nxt;
  logic tick_r, tick_nxt;

  always_comb begin
    div_nxt = (div_r == DIV_LAST) ? '0 : DIV_W'(div_r + 1'b1);
    tick_nxt = (div_r == DIV_LAST);
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      div_r <= '0;
      tick_r <= 1'b0;
    end else begin
      div_r <= div_nxt;
      tick_r <= tick_nxt;
    end
  end

  // channel state
  logic start_r, start_nxt;
  tmr_pkg::mode_t mode_r, mode_nxt;
  logic trig_ext_r, trig_ext_nxt;
  logic up_r, up_nxt;
  logic free_r, free_nxt;
  logic two_ph_r, two_ph_nxt;
  logic [tmr_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
  logic [tmr_pkg::CNT_W-1:0] reload_r, reload_nxt;
  logic run_r, run_nxt;
  logic pend_r, pend_nxt;
  logic retrig_r, retrig_nxt;
  logic out_r, out_nxt;
  logic oe_r, oe_nxt;
  logic stat_r, stat_nxt;
  logic mask_r, mask_nxt;
  logic irq_r, irq_nxt;
  logic [tmr_pkg::CNT_W-1:0] rdata_r, rdata_nxt;
  logic rl_now;
  logic [tmr_pkg::CNT_W-1:0] rl_val;
  logic set_irq;
  logic ev_pulse;
  logic ev_up;
  logic trig;
  logic wr_ctrl, wr_count, wr_stat, wr_mask;
  tmr_pkg::mode_t wmode;

  always_comb begin
    start_nxt = start_r;
    mode_nxt = mode_r;
    trig_ext_nxt = trig_ext_r;
    up_nxt = up_r;
    free_nxt = free_r;
    two_ph_nxt = two_ph_r;
    cnt_nxt = cnt_r;
    reload_nxt = reload_r;
    run_nxt = run_r;
    pend_nxt = pend_r;
    retrig_nxt = retrig_r;
    out_nxt = out_r;
    mask_nxt = mask_r;
    rl_now = 1'b0;
    rl_val = tmr_pkg::CNT_ONES;
    set_irq = 1'b0;
    wr_ctrl = wr_en && (addr == tmr_pkg::ADDR_CTRL);
    wr_count = wr_en && (addr == tmr_pkg::ADDR_COUNT);
    wr_stat = wr_en && (addr == tmr_pkg::ADDR_STAT);
    wr_mask = wr_en && (addr == tmr_pkg::ADDR_MASK);
    wmode = tmr_pkg::mode_t'(wdata[tmr_pkg::CTRL_MODE +: 2]);
    ev_up = (two_ph_r && TWO_PH_OK) ? pins.lvl[tmr_pkg::PIN_OUT] : up_r;
    ev_pulse = (two_ph_r && TWO_PH_OK) ? pins.rise[tmr_pkg::PIN_PHASE] : pins.rise[tmr_pkg::PIN_TRIG];
    trig = trig_ext_r ? pins.rise[tmr_pkg::PIN_TRIG] : (wr_ctrl && wdata[tmr_pkg::CTRL_SW_TRIG]);

    if (start_r) begin
      case (mode_r)
        tmr_pkg::MODE_TIMER: begin
          if (tick_r) begin
            if (cnt_r == tmr_pkg::CNT_ZERO) begin
              cnt_nxt = reload_r;
              rl_now = 1'b1;
              set_irq = 1'b1;
            end else begin
              cnt_nxt = step(cnt_r, 1'b0);
            end
          end
        end
        tmr_pkg::MODE_EVENT: begin
          if (ev_pulse) begin
            if (ev_up && cnt_r == tmr_pkg::CNT_ONES) begin
              cnt_nxt = free_r ? tmr_pkg::CNT_ZERO : reload_r;
              rl_now = 1'b1;
              rl_val = tmr_pkg::CNT_ZERO;
              set_irq = 1'b1;
            end else if (!ev_up && cnt_r == tmr_pkg::CNT_ZERO) begin
              cnt_nxt = free_r ? tmr_pkg::CNT_ONES : reload_r;
              rl_now = 1'b1;
              rl_val = tmr_pkg::CNT_ONES;
              set_irq = 1'b1;
            end else begin
              cnt_nxt = step(cnt_r, ev_up);
            end
          end
        end
        tmr_pkg::MODE_ONESHOT: begin
          // triggers wait for the count source so the output lines up with it
          if (trig) begin
            pend_nxt = 1'b1;
          end
          if (tick_r) begin
            if (pend_r && !run_r) begin
              pend_nxt = trig;
              run_nxt = 1'b1;
              out_nxt = 1'b1;
              cnt_nxt = reload_r;
            end else if (run_r && retrig_r) begin
              retrig_nxt = 1'b0;
              cnt_nxt = reload_r;
            end else if (run_r && pend_r) begin
              pend_nxt = trig;
              retrig_nxt = 1'b1;
              cnt_nxt = step(cnt_r, 1'b0);
            end else if (run_r) begin
              if (cnt_r == tmr_pkg::CNT_ZERO) begin
                run_nxt = 1'b0;
                out_nxt = 1'b0;
                cnt_nxt = reload_r;
                set_irq = 1'b1;
              end else begin
                cnt_nxt = step(cnt_r, 1'b0);
              end
            end
          end
        end
        tmr_pkg::MODE_PWM: begin
          if (tick_r) begin
            if (cnt_r == tmr_pkg::CNT_ZERO) begin
              out_nxt = !out_r;
              cnt_nxt = out_r ? ~reload_r : reload_r;
              set_irq = out_r;
            end else begin
              cnt_nxt = step(cnt_r, 1'b0);
            end
          end
        end
        default: begin
          cnt_nxt = cnt_r;
        end
      endcase
    end

    if (wr_count) begin
      reload_nxt = wdata;
      if (!start_r) begin
        cnt_nxt = wdata;
      end
    end

    if (wr_ctrl) begin
      start_nxt = wdata[tmr_pkg::CTRL_START];
      mode_nxt = wmode;
      trig_ext_nxt = wdata[tmr_pkg::CTRL_TRIG_EXT];
      up_nxt = wdata[tmr_pkg::CTRL_UP];
      free_nxt = wdata[tmr_pkg::CTRL_FREE];
      two_ph_nxt = wdata[tmr_pkg::CTRL_TWO_PH] && TWO_PH_OK;
      if (timed_mode(mode_r) && !timed_mode(wmode)) begin
        set_irq = 1'b1;
      end
      if (start_r && !wdata[tmr_pkg::CTRL_START]) begin
        if (mode_r == tmr_pkg::MODE_ONESHOT && run_r) begin
          run_nxt = 1'b0;
          pend_nxt = 1'b0;
          retrig_nxt = 1'b0;
          cnt_nxt = reload_r;
          out_nxt = 1'b0;
          set_irq = 1'b1;
        end else if (mode_r == tmr_pkg::MODE_PWM) begin
          out_nxt = 1'b0;
          set_irq = set_irq || out_r;
        end
      end
      if (!start_r && wdata[tmr_pkg::CTRL_START]) begin
        // reset sequencing state on each start; PWM begins with its high phase
        run_nxt = 1'b0;
        pend_nxt = 1'b0;
        retrig_nxt = 1'b0;
        out_nxt = (wmode == tmr_pkg::MODE_PWM);
        if (wmode == tmr_pkg::MODE_PWM) begin
          cnt_nxt = reload_r;
        end
      end
      if (!wdata[tmr_pkg::CTRL_START] && !start_r) begin
        out_nxt = 1'b0;
      end
    end

    oe_nxt = !(mode_nxt == tmr_pkg::MODE_EVENT && two_ph_nxt);
    // a hardware set in the same cycle as a clear wins
    stat_nxt = (wr_stat && wdata[tmr_pkg::STAT_IRQ]) ? 1'b0 : stat_r;
    stat_nxt = stat_nxt || set_irq;
    if (wr_mask) begin
      mask_nxt = wdata[tmr_pkg::STAT_IRQ];
    end
    irq_nxt = stat_nxt && mask_nxt;

    rdata_nxt = '0;
    if (rd_en) begin
      case (addr)
        tmr_pkg::ADDR_CTRL: rdata_nxt = tmr_pkg::CNT_W'({two_ph_r, free_r, up_r, trig_ext_r, mode_r, start_r});
        tmr_pkg::ADDR_COUNT: rdata_nxt = rl_now ? rl_val : cnt_r;
        tmr_pkg::ADDR_STAT: rdata_nxt = tmr_pkg::CNT_W'({out_r, run_r, stat_r});
        tmr_pkg::ADDR_MASK: rdata_nxt = tmr_pkg::CNT_W'(mask_r);
        default: rdata_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      start_r <= 1'b0;
      mode_r <= tmr_pkg::MODE_TIMER;
      trig_ext_r <= 1'b0;
      up_r <= 1'b0;
      free_r <= 1'b0;
      two_ph_r <= 1'b0;
      cnt_r <= tmr_pkg::CNT_RST;
      reload_r <= tmr_pkg::CNT_RST;
      run_r <= 1'b0;
      pend_r <= 1'b0;
      retrig_r <= 1'b0;
      out_r <= 1'b0;
      oe_r <= 1'b1;
      stat_r <= 1'b0;
      mask_r <= 1'b0;
      irq_r <= 1'b0;
      rdata_r <= '0;
    end else begin
      start_r <= start_nxt;
      mode_r <= mode_nxt;
      trig_ext_r <= trig_ext_nxt;
      up_r <= up_nxt;
      free_r <= free_nxt;
      two_ph_r <= two_ph_nxt;
      cnt_r <= cnt_nxt;
      reload_r <= reload_nxt;
      run_r <= run_nxt;
      pend_r <= pend_nxt;
      retrig_r <= retrig_nxt;
      out_r <= out_nxt;
      oe_r <= oe_nxt;
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
      irq_r <= irq_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign rdata = rdata_r;
  assign timer_output_pin_out = out_r;
  assign timer_output_pin_oe = oe_r;
  assign irq = irq_r;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  start_by_write_a: assert property ($rose(start_r) |-> $past(wr_ctrl && wdata[tmr_pkg::CTRL_START]))
    else $error("start flag rose without a software write");
  live_read_a: assert property (rd_en && addr == tmr_pkg::ADDR_COUNT && !rl_now |=> rdata == $past(cnt_r))
    else $error("count read did not return the live counter");
  timer_reload_read_a: assert property (rd_en && addr == tmr_pkg::ADDR_COUNT && rl_now
      && mode_r == tmr_pkg::MODE_TIMER |=> rdata == tmr_pkg::CNT_ONES)
    else $error("timer reload read not all ones");
  event_reload_read_a: assert property (rd_en && addr == tmr_pkg::ADDR_COUNT && rl_now
      && mode_r == tmr_pkg::MODE_EVENT |=> rdata == ($past(ev_up) ? tmr_pkg::CNT_ZERO : tmr_pkg::CNT_ONES))
    else $error("event reload read has wrong value");
  halted_write_a: assert property (wr_count && !start_r |=> cnt_r == $past(wdata) && reload_r == $past(wdata))
    else $error("halted count write not visible");
  oneshot_stop_a: assert property (wr_ctrl && !wdata[tmr_pkg::CTRL_START] && start_r && run_r
      && mode_r == tmr_pkg::MODE_ONESHOT |=> !out_r && stat_r && cnt_r == $past(reload_r))
    else $error("one-shot stop did not reload, drop output and flag");
  mode_irq_a: assert property (wr_ctrl && timed_mode(mode_r) && !timed_mode(wmode) |=> stat_r)
    else $error("mode change to one-shot or PWM did not flag");
  pwm_stop_high_a: assert property (wr_ctrl && !wdata[tmr_pkg::CTRL_START] && start_r
      && mode_r == tmr_pkg::MODE_PWM && out_r |=> !out_r && stat_r && !start_r)
    else $error("PWM stop from high level misbehaved");
  pwm_stop_low_a: assert property (wr_ctrl && !wdata[tmr_pkg::CTRL_START] && start_r && !stat_r
      && mode_r == tmr_pkg::MODE_PWM && wmode == tmr_pkg::MODE_PWM && !out_r |=> !out_r && !stat_r)
    else $error("PWM stop from low level changed pin or flag");
  retrig_once_a: assert property (retrig_r && tick_r && start_r && mode_r == tmr_pkg::MODE_ONESHOT
      && !wr_ctrl |=> cnt_r == $past(reload_r) && !retrig_r)
    else $error("retrigger did not reload after one decrement");
  irq_out_a: assert property (##1 irq == (stat_r && mask_r))
    else $error("interrupt output disagrees with status and mask");

  oneshot_run_c: cover property (mode_r == tmr_pkg::MODE_ONESHOT && $fell(run_r) && stat_r);
  pwm_cycle_c: cover property (mode_r == tmr_pkg::MODE_PWM && $rose(out_r) ##[1:300] $fell(out_r));
  event_ovf_c: cover property (mode_r == tmr_pkg::MODE_EVENT && rl_now && rl_val == tmr_pkg::CNT_ZERO);
  timer_reload_c: cover property (mode_r == tmr_pkg::MODE_TIMER && rl_now && rd_en);
endmodule : timer_a_multimode_counter

/* tmr_pulse_src.sv */
// far-side model: trigger pulses, phase pulses and the level put on the shared output pin
// assumes ref_clk from the bench; every pin change lands just after a rising edge
`timescale 1ns/1ps
module tmr_pulse_src (
  input wire logic ref_clk,
  input wire logic oe,
  output logic trig,
  output logic phase,
  output logic drv
);
  logic dir_r = 1'h0;
  initial begin
    trig = 1'h0;
    phase = 1'h0;
  end
  // level offered on the output pin; the bench uses it only while oe is low
  assign drv = dir_r;
  // each pulse is 8 clocks high and 8 low, far wider than one count source cycle
  task automatic pulse(input bit on_phase, input int cnt);
    for (int i = 0; i < cnt; i++) begin
      @(posedge ref_clk);
      if (on_phase) begin
        phase <= 1'h1;
      end else begin
        trig <= 1'h1;
      end
      repeat (8) @(posedge ref_clk);
      trig <= 1'h0;
      phase <= 1'h0;
      repeat (8) @(posedge ref_clk);
    end
  endtask : pulse
  task automatic set_dir(input logic up);
    @(posedge ref_clk);
    dir_r <= up;
  endtask : set_dir
endmodule : tmr_pulse_src

/* timer_a_multimode_counter_tb_top.sv */
// self-checking bench for the multimode timer channel through its register port
// assumes the channel and the pulse source model are compiled first; 125 MHz clock
`timescale 1ns/1ps
module timer_a_multimode_counter_tb_top;
  localparam int SD = 2;
  localparam logic [tmr_pkg::ADDR_W-1:0] CT = tmr_pkg::ADDR_CTRL;
  localparam logic [tmr_pkg::ADDR_W-1:0] CN = tmr_pkg::ADDR_COUNT;
  localparam logic [tmr_pkg::ADDR_W-1:0] ST = tmr_pkg::ADDR_STAT;
  localparam logic [tmr_pkg::ADDR_W-1:0] MK = tmr_pkg::ADDR_MASK;
  logic ref_clk = 1'h0;
  logic rst_b = 1'h0;
  logic [tmr_pkg::ADDR_W-1:0] addr = 4'h0;
  logic [tmr_pkg::CNT_W-1:0] wdata = 16'h0000;
  logic wr_en = 1'h0;
  logic rd_en = 1'h0;
  logic [tmr_pkg::CNT_W-1:0] rdata;
  logic [tmr_pkg::CNT_W-1:0] v;
  logic trig, phase, drv, pin_out, pin_oe, irq, pin_lvl;
  int fails = 0;
  int comparisons = 0;
  int n, ones, zeros;
  // the output pin wire: channel level while it drives, far side level otherwise
  assign pin_lvl = pin_oe ? pin_out : drv;
  timer_a_multimode_counter #(.SRC_DIV(SD), .CH_IDX(2)) dut (.ref_clk(ref_clk), .rst_b(rst_b), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .timer_trigger_input_pin(trig),
    .timer_phase_input_pin(phase), .timer_output_pin_in(pin_lvl), .timer_output_pin_out(pin_out),
    .timer_output_pin_oe(pin_oe), .irq(irq));
  tmr_pulse_src src (.ref_clk(ref_clk), .oe(pin_oe), .trig(trig), .phase(phase), .drv(drv));
  always #4 ref_clk = ~ref_clk;
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : print_verdict
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'h1;
    @(posedge ref_clk);
    wr_en <= 1'h0;
    #1;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    addr <= a;
    rd_en <= 1'h1;
    @(posedge ref_clk);
    rd_en <= 1'h0;
    #1 d = rdata;
  endtask : rd
  task automatic rchk(input string what, input logic [3:0] a, input logic [15:0] exp, input logic [15:0] m = 16'hffff);
    logic [15:0] d;
    rd(a, d);
    check(what, d & m, exp);
  endtask : rchk
  // one read per cycle, counting all-ones and all-zeros answers
  task automatic burst(input int k, output int o, output int z);
    o = 0;
    z = 0;
    @(posedge ref_clk);
    addr <= CN;
    rd_en <= 1'h1;
    repeat (k) begin
      @(posedge ref_clk);
      #1;
      o += int'(rdata === 16'hffff);
      z += int'(rdata === 16'h0000);
    end
    @(posedge ref_clk);
    rd_en <= 1'h0;
  endtask : burst
  task automatic wait_out(input logic lvl, output int c);
    c = 0;
    #1;
    while (pin_out !== lvl && c < 200) begin
      @(posedge ref_clk);
      #1 c++;
    end
  endtask : wait_out
  initial begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    print_verdict();
  end
  initial begin
    repeat (5) @(posedge ref_clk);
    check("reset out/oe/irq", {13'h0000, pin_out, pin_oe, irq}, 16'h0002);
    rst_b <= 1'h1;
    rchk("ctrl after reset", CT, 16'h0000);
    wr(CN, 16'h0005);
    repeat (20) @(posedge ref_clk);
    rchk("halted count", CN, 16'h0005);
    wr(4'h2, 16'hffff);
    rchk("unmapped read", 4'h2, 16'h0000);
    rchk("ctrl untouched", CT, 16'h0000);
    wr(CT, 16'h0001);
    burst(6 * SD, ones, zeros);
    check("timer reload reads", 16'(ones), 16'h0001);
    rchk("reload flag", ST, 16'h0001, 16'h0001);
    wr(CT, 16'h0000);
    wr(CN, 16'h0100);
    wr(CT, 16'h0001);
    rd(CN, v);
    check("count running", {15'h0000, v < 16'h0100}, 16'h0001);
    repeat (18) @(posedge ref_clk);
    rchk("live count", CN, v - 16'(20 / SD));
    // event counting down through an underflow
    wr(CT, 16'h0002);
    wr(ST, 16'h0001);
    wr(CN, 16'h0002);
    wr(CT, 16'h0003);
    fork
      burst(80, ones, zeros);
      src.pulse(1'b0, 3);
    join
    check("underflow reads", 16'(ones), 16'h0001);
    rchk("underflow reload", CN, 16'h0002);
    // event counting up through an overflow, then the free-running variant
    wr(CT, 16'h0012);
    wr(CN, 16'hfffe);
    wr(CT, 16'h0013);
    fork
      burst(60, ones, zeros);
      src.pulse(1'b0, 2);
    join
    check("overflow reads", 16'(zeros), 16'h0001);
    rchk("overflow reload", CN, 16'hfffe);
    wr(CT, 16'h0032);
    wr(CN, 16'hfffe);
    wr(CT, 16'h0033);
    src.pulse(1'b0, 2);
    rchk("free-run wrap", CN, 16'h0000);
    // two-phase counting, direction taken from the output pin level
    wr(CT, 16'h0002);
    wr(CN, 16'h0010);
    src.set_dir(1'h1);
    wr(CT, 16'h0043);
    check("pin released", {15'h0000, pin_oe}, 16'h0000);
    src.pulse(1'b1, 2);
    rchk("two-phase up", CN, 16'h0012);
    src.set_dir(1'h0);
    src.pulse(1'b1, 1);
    rchk("two-phase down", CN, 16'h0011);
    wr(CT, 16'h0002);
    // one-shot: mode flag, mask, external trigger, retrigger, stop
    wr(CT, 16'h0004);
    rchk("one-shot mode flag", ST, 16'h0001, 16'h0001);
    check("masked irq", {15'h0000, irq}, 16'h0000);
    wr(MK, 16'h0001);
    rchk("mask reads", MK, 16'h0001, 16'h0001);
    check("irq raised", {15'h0000, irq}, 16'h0001);
    wr(ST, 16'h0001);
    rchk("flag cleared", ST, 16'h0000, 16'h0001);
    check("irq cleared", {15'h0000, irq}, 16'h0000);
    wr(CN, 16'h0003);
    wr(CT, 16'h000d);
    fork
      src.pulse(1'b0, 1);
      wait_out(1'h1, n);
    join_any
    check("trigger to output", {15'h0000, n <= 6 + SD}, 16'h0001);
    wait_out(1'h0, n);
    check("one-shot width", 16'(n), 16'(4 * SD));
    wr(ST, 16'h0001);
    // leave the external trigger select first: the software trigger bit obeys the select already held
    wr(CT, 16'h0005);
    wr(CT, 16'h0085);
    wait_out(1'h1, n);
    repeat (2 * SD - 2) @(posedge ref_clk);
    wr(CT, 16'h0085);
    wait_out(1'h0, n);
    check("retrigger stretch", {15'h0000, n >= 5 * SD && n <= 6 * SD + 1}, 16'h0001);
    wr(ST, 16'h0001);
    wr(CT, 16'h0085);
    wait_out(1'h1, n);
    wr(CT, 16'h0004);
    @(posedge ref_clk);
    #1;
    check("stop drops output", {15'h0000, pin_out}, 16'h0000);
    check("stop raises irq", {15'h0000, irq}, 16'h0001);
    rchk("stop reloads", CN, 16'h0003);
    // pwm: mode flag, stop while low, stop while high
    wr(CT, 16'h0000);
    wr(ST, 16'h0001);
    wr(CT, 16'h0006);
    rchk("pwm mode flag", ST, 16'h0001, 16'h0001);
    wr(ST, 16'h0001);
    wr(CN, 16'h0003);
    wr(CT, 16'h0007);
    wait_out(1'h0, n);
    check("pwm high phase", {15'h0000, n >= 3 * SD && n <= 5 * SD}, 16'h0001);
    wr(ST, 16'h0001);
    wr(CT, 16'h0006);
    @(posedge ref_clk);
    #1;
    check("stop while low", {15'h0000, pin_out}, 16'h0000);
    rchk("no flag when low", ST, 16'h0000, 16'h0001);
    wr(CT, 16'h0007);
    check("pwm restart high", {15'h0000, pin_out}, 16'h0001);
    wr(CT, 16'h0006);
    @(posedge ref_clk);
    #1;
    check("stop while high", {15'h0000, pin_out}, 16'h0000);
    rchk("flag when high", ST, 16'h0001, 16'h0001);
    print_verdict();
  end
endmodule : timer_a_multimode_counter_tb_top
